// File: tips_pkg.sv
// Package for the timer capture and high interrupt pin select block.
// Holds register offsets, field layouts, reset values and pin carriers.
// Assumes an AXI4-Lite master with 32-bit data and a single clock.

package tips_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int unsigned TIPS_ADDR_W = 4;
    localparam logic [3:0] TIPS_OFS_TMR_SEL = 4'h0;
    localparam logic [3:0] TIPS_OFS_IRQ_SEL = 4'h4;
    localparam logic [3:0] TIPS_OFS_PIN_STATE = 4'h8;

    // ------------------------------------------------------------
    // Field positions in timer_capture_pin_select
    // ------------------------------------------------------------
    localparam int unsigned TIPS_CH5A_CAPTURE_ROUTE = 7;
    localparam int unsigned TIPS_CH4A_CAPTURE_ROUTE = 6;
    localparam int unsigned TIPS_CH3A_CAPTURE_ROUTE = 5;
    localparam int unsigned TIPS_CH3C_CAPTURE_ROUTE = 4;
    localparam int unsigned TIPS_CH2A_CAPTURE_ROUTE = 3;
    localparam int unsigned TIPS_CH1A_CAPTURE_ROUTE = 2;
    localparam int unsigned TIPS_CH0A_CAPTURE_ROUTE = 1;
    localparam int unsigned TIPS_CH0C_CAPTURE_ROUTE = 0;

    // ------------------------------------------------------------
    // Field positions in high_irq_pin_select
    // ------------------------------------------------------------
    localparam int unsigned TIPS_REQ11_SOURCE_SEL = 3;
    localparam int unsigned TIPS_REQ10_SOURCE_SEL = 2;
    localparam int unsigned TIPS_REQ9_SOURCE_SEL = 1;
    localparam int unsigned TIPS_REQ8_SOURCE_SEL = 0;
    localparam int unsigned TIPS_IRQ_SEL_W = 4;

    // ------------------------------------------------------------
    // Reset values and bus answers
    // ------------------------------------------------------------
    localparam logic [7:0] TIPS_TMR_SEL_RESET = 8'h00;
    localparam logic [3:0] TIPS_IRQ_SEL_RESET = 4'h0;
    localparam logic [1:0] TIPS_RESP_OKAY = 2'h0;
    localparam logic [1:0] TIPS_RESP_SLVERR = 2'h2;

    // Pin index in the joined vector {port 3, port 2}.
    localparam int unsigned TIPS_PORT3_BASE = 8;

    // Compare drive from the timer channels, one bit per function.
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] oe;
    } tips_cmp_type;

    // Drive toward the port 2 and port 3 pads, port 3 in the upper byte.
    typedef struct packed {
        logic [15:0] level;
        logic [15:0] oe;
    } tips_pad_type;

endpackage

// File: tips_pin_sync.sv
// Three-stage synchroniser with agreement filter for pad inputs.
// Assumes the inputs are asynchronous to aclk.
`timescale 1ns/1ps
`default_nettype none

module tips_pin_sync #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] pin_async,
    output logic      [WIDTH-1:0] pin_level
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (WIDTH < 1) begin : g_bad_width
        $error("tips_pin_sync needs WIDTH of at least 1.");
    end

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
        logic [WIDTH-1:0] stage3;
        logic [WIDTH-1:0] level;
    } tips_sync_type;

    tips_sync_type s;
    tips_sync_type next_s;

    // Shift the pads in and accept a level once stages two and three agree.
    always_comb begin
        next_s = s;
        next_s.stage1 = pin_async;
        next_s.stage2 = s.stage1;
        next_s.stage3 = s.stage2;
        for (int i = 0; i < WIDTH; i++) begin
            if (s.stage2[i] == s.stage3[i]) begin
                next_s.level[i] = s.stage2[i];
            end
        end
    end

    // Register the state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pin_level = s.level;

endmodule
`default_nettype wire

// File: tips_pin_select.sv
// Timer capture and high interrupt pin select block with AXI4-Lite access.
// Assumes the timer and interrupt logic run on aclk and the pads are asynchronous.
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module tips_pin_select
    import tips_pkg::*;
(
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // AXI4-Lite write address channel.
    input  wire logic [TIPS_ADDR_W-1:0] awaddr,
    input  wire logic [2:0]             awprot,
    input  wire logic                   awvalid,
    output logic                        awready,
    // AXI4-Lite write data channel.
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output logic                        wready,
    // AXI4-Lite write response channel.
    output logic [1:0]                  bresp,
    output logic                        bvalid,
    input  wire logic                   bready,
    // AXI4-Lite read address channel.
    input  wire logic [TIPS_ADDR_W-1:0] araddr,
    input  wire logic [2:0]             arprot,
    input  wire logic                   arvalid,
    output logic                        arready,
    // AXI4-Lite read data channel.
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    output logic                        rvalid,
    input  wire logic                   rready,
    // Pads of port 2, port 3 and the low half of port 6.
    input  wire logic [7:0]             port2_in,
    input  wire logic [7:0]             port3_in,
    input  wire logic [3:0]             port6_in,
    output tips_pad_type                pad_drive,
    // Timer side: compare drive in, capture levels out.
    input  wire tips_cmp_type           timer_compare,
    output logic [7:0]                  timer_capture,
    // Interrupt side: requests 11 down to 8.
    output logic [3:0]                  irq_request
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic                   awready;
        logic                   wready;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   arready;
        logic                   rvalid;
        logic [1:0]             rresp;
        logic [31:0]            rdata;
        logic                   aw_held;
        logic [TIPS_ADDR_W-1:0] aw_addr;
        logic                   w_held;
        logic [7:0]             w_data;
        logic                   w_lane0;
        logic [7:0]             tmr_sel;
        logic [3:0]             irq_sel;
        logic [7:0]             capture;
        logic [3:0]             irq;
        tips_pad_type           pad;
    } tips_state_type;

    tips_state_type s;
    tips_state_type next_s;

    logic [7:0] port2_level;
    logic [7:0] port3_level;
    logic [3:0] port6_level;

    // ------------------------------------------------------------
    // Pad synchronisers
    // ------------------------------------------------------------

    // Port 2 carries timer pins and the A sources of requests 8 to 11.
    tips_pin_sync #(
        .WIDTH(8)
    ) u_sync_port2 (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pin_async(port2_in),
        .pin_level(port2_level)
    );

    // Port 3 carries the timer pins of channels 0 to 2.
    tips_pin_sync #(
        .WIDTH(8)
    ) u_sync_port3 (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pin_async(port3_in),
        .pin_level(port3_level)
    );

    // Port 6 carries the B sources of requests 8 to 11.
    tips_pin_sync #(
        .WIDTH(4)
    ) u_sync_port6 (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pin_async(port6_in),
        .pin_level(port6_level)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Picks the alternate pin when the select is set, the shared pin otherwise.
    function automatic logic pick(input logic sel, input logic shared_pin, input logic alt_pin);
        pick = sel ? alt_pin : shared_pin;
    endfunction

    // Tells whether a word address names one of the three registers.
    function automatic logic mapped(input logic [TIPS_ADDR_W-1:0] addr);
        mapped = (addr == TIPS_OFS_TMR_SEL) || (addr == TIPS_OFS_IRQ_SEL)
              || (addr == TIPS_OFS_PIN_STATE);
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    logic                   aw_take;
    logic                   w_take;
    logic                   ar_take;
    logic                   have_aw;
    logic                   have_w;
    logic [TIPS_ADDR_W-1:0] wr_addr;
    logic [TIPS_ADDR_W-1:0] rd_addr;
    logic [7:0]             wr_byte;
    logic                   wr_lane0;

    // Handshakes seen at this edge, merged with any half already held.
    always_comb begin
        aw_take = awvalid && s.awready;
        w_take = wvalid && s.wready;
        ar_take = arvalid && s.arready;
        have_aw = s.aw_held || aw_take;
        have_w = s.w_held || w_take;
        wr_addr = s.aw_held ? s.aw_addr : {awaddr[TIPS_ADDR_W-1:2], 2'h0};
        wr_byte = s.w_held ? s.w_data : wdata[7:0];
        wr_lane0 = s.w_held ? s.w_lane0 : wstrb[0];
        rd_addr = {araddr[TIPS_ADDR_W-1:2], 2'h0};
    end

    always_comb begin
        next_s = s;

        // Write path: hold whichever half arrives first.
        if (aw_take) begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = wr_addr;
        end
        if (w_take) begin
            next_s.w_held = 1'b1;
            next_s.w_data = wr_byte;
            next_s.w_lane0 = wr_lane0;
        end

        // Retire the response once the master takes it.
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end

        // Both halves present: update the register and answer in the same edge.
        if (have_aw && have_w && !s.bvalid) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = TIPS_RESP_OKAY;
            if (wr_addr == TIPS_OFS_TMR_SEL) begin
                if (wr_lane0) begin
                    next_s.tmr_sel = wr_byte;
                end
            end else if (wr_addr == TIPS_OFS_IRQ_SEL) begin
                if (wr_lane0) begin
                    next_s.irq_sel = wr_byte[TIPS_IRQ_SEL_W-1:0];
                end
            end else begin
                // The status word and unmapped words refuse writes.
                next_s.bresp = TIPS_RESP_SLVERR;
            end
        end

        // A new half is accepted only while neither it nor a response is pending.
        next_s.awready = !next_s.aw_held && !next_s.bvalid;
        next_s.wready = !next_s.w_held && !next_s.bvalid;

        // Read path: one read at a time, data fixed until taken.
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (ar_take) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = mapped(rd_addr) ? TIPS_RESP_OKAY : TIPS_RESP_SLVERR;
            next_s.rdata = 32'h0000_0000;
            if (rd_addr == TIPS_OFS_TMR_SEL) begin
                next_s.rdata[7:0] = s.tmr_sel;
            end else if (rd_addr == TIPS_OFS_IRQ_SEL) begin
                next_s.rdata[TIPS_IRQ_SEL_W-1:0] = s.irq_sel;
            end else if (rd_addr == TIPS_OFS_PIN_STATE) begin
                next_s.rdata[11:0] = {s.irq, s.capture};
            end
        end
        next_s.arready = !next_s.rvalid;

        // Capture routing from the current selects.
        next_s.capture[TIPS_CH5A_CAPTURE_ROUTE] =
            pick(s.tmr_sel[TIPS_CH5A_CAPTURE_ROUTE], port2_level[6], port2_level[7]);
        next_s.capture[TIPS_CH4A_CAPTURE_ROUTE] =
            pick(s.tmr_sel[TIPS_CH4A_CAPTURE_ROUTE], port2_level[5], port2_level[4]);
        next_s.capture[TIPS_CH3A_CAPTURE_ROUTE] =
            pick(s.tmr_sel[TIPS_CH3A_CAPTURE_ROUTE], port2_level[1], port2_level[0]);
        next_s.capture[TIPS_CH3C_CAPTURE_ROUTE] =
            pick(s.tmr_sel[TIPS_CH3C_CAPTURE_ROUTE], port2_level[2], port2_level[3]);
        next_s.capture[TIPS_CH2A_CAPTURE_ROUTE] =
            pick(s.tmr_sel[TIPS_CH2A_CAPTURE_ROUTE], port3_level[6], port3_level[7]);
        next_s.capture[TIPS_CH1A_CAPTURE_ROUTE] =
            pick(s.tmr_sel[TIPS_CH1A_CAPTURE_ROUTE], port3_level[4], port3_level[5]);
        next_s.capture[TIPS_CH0A_CAPTURE_ROUTE] =
            pick(s.tmr_sel[TIPS_CH0A_CAPTURE_ROUTE], port3_level[0], port3_level[1]);
        next_s.capture[TIPS_CH0C_CAPTURE_ROUTE] =
            pick(s.tmr_sel[TIPS_CH0C_CAPTURE_ROUTE], port3_level[2], port3_level[3]);

        // Interrupt request routing from the current selects.
        next_s.irq[TIPS_REQ11_SOURCE_SEL] =
            pick(s.irq_sel[TIPS_REQ11_SOURCE_SEL], port2_level[3], port6_level[3]);
        next_s.irq[TIPS_REQ10_SOURCE_SEL] =
            pick(s.irq_sel[TIPS_REQ10_SOURCE_SEL], port2_level[2], port6_level[2]);
        next_s.irq[TIPS_REQ9_SOURCE_SEL] =
            pick(s.irq_sel[TIPS_REQ9_SOURCE_SEL], port2_level[1], port6_level[1]);
        next_s.irq[TIPS_REQ8_SOURCE_SEL] =
            pick(s.irq_sel[TIPS_REQ8_SOURCE_SEL], port2_level[0], port6_level[0]);

        // Compare drive always stays on the shared pin, whatever the select.
        next_s.pad = '0;
        next_s.pad.level[6] = timer_compare.level[TIPS_CH5A_CAPTURE_ROUTE];
        next_s.pad.oe[6] = timer_compare.oe[TIPS_CH5A_CAPTURE_ROUTE];
        next_s.pad.level[5] = timer_compare.level[TIPS_CH4A_CAPTURE_ROUTE];
        next_s.pad.oe[5] = timer_compare.oe[TIPS_CH4A_CAPTURE_ROUTE];
        next_s.pad.level[1] = timer_compare.level[TIPS_CH3A_CAPTURE_ROUTE];
        next_s.pad.oe[1] = timer_compare.oe[TIPS_CH3A_CAPTURE_ROUTE];
        next_s.pad.level[2] = timer_compare.level[TIPS_CH3C_CAPTURE_ROUTE];
        next_s.pad.oe[2] = timer_compare.oe[TIPS_CH3C_CAPTURE_ROUTE];
        next_s.pad.level[TIPS_PORT3_BASE + 6] = timer_compare.level[TIPS_CH2A_CAPTURE_ROUTE];
        next_s.pad.oe[TIPS_PORT3_BASE + 6] = timer_compare.oe[TIPS_CH2A_CAPTURE_ROUTE];
        next_s.pad.level[TIPS_PORT3_BASE + 4] = timer_compare.level[TIPS_CH1A_CAPTURE_ROUTE];
        next_s.pad.oe[TIPS_PORT3_BASE + 4] = timer_compare.oe[TIPS_CH1A_CAPTURE_ROUTE];
        next_s.pad.level[TIPS_PORT3_BASE + 0] = timer_compare.level[TIPS_CH0A_CAPTURE_ROUTE];
        next_s.pad.oe[TIPS_PORT3_BASE + 0] = timer_compare.oe[TIPS_CH0A_CAPTURE_ROUTE];
        next_s.pad.level[TIPS_PORT3_BASE + 2] = timer_compare.level[TIPS_CH0C_CAPTURE_ROUTE];
        next_s.pad.oe[TIPS_PORT3_BASE + 2] = timer_compare.oe[TIPS_CH0C_CAPTURE_ROUTE];
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------

    // Synchronous reset clears the bus and returns every select to zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.tmr_sel <= TIPS_TMR_SEL_RESET;
            s.irq_sel <= TIPS_IRQ_SEL_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------
    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rresp = s.rresp;
    assign rdata = s.rdata;
    assign pad_drive = s.pad;
    assign timer_capture = s.capture;
    assign irq_request = s.irq;

endmodule
`default_nettype wire

// File: tips_pin_select_properties.sv
// Concurrent checks on the ports of the pin select block.
// Assumes a bind to tips_pin_select, one clock aclk and reset aresetn.
`timescale 1ns/1ps
`default_nettype none

module tips_pin_select_properties
    import tips_pkg::*;
(
    input wire logic         aclk,
    input wire logic         aresetn,
    input wire logic         awvalid,
    input wire logic         awready,
    input wire logic         wvalid,
    input wire logic         wready,
    input wire logic [1:0]   bresp,
    input wire logic         bvalid,
    input wire logic         bready,
    input wire logic         arvalid,
    input wire logic         arready,
    input wire logic [31:0]  rdata,
    input wire logic         rvalid,
    input wire logic         rready,
    input wire logic [7:0]   port2_in,
    input wire logic [7:0]   port3_in,
    input wire logic [3:0]   port6_in,
    input wire tips_pad_type pad_drive,
    input wire tips_cmp_type timer_compare,
    input wire logic [7:0]   timer_capture,
    input wire logic [3:0]   irq_request
);
    // ----------------------------------------------------------
    // Compare functions spread onto their shared pad positions
    // ----------------------------------------------------------
    function automatic logic [15:0] spread(input logic [7:0] v);
        return {1'b0, v[3], 1'b0, v[2], 1'b0, v[0], 1'b0, v[1], 1'b0, v[7], v[6], 2'h0, v[4], v[5], 1'b0};
    endfunction

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_cmp_oe_map: assert property ($past(aresetn) |-> pad_drive.oe == spread($past(timer_compare.oe)))
        else $error("compare enable not on its shared pad");
    chk_cmp_lvl_map: assert property ($past(aresetn) |-> (pad_drive.level & 16'h5566) == spread($past(timer_compare.level)))
        else $error("compare level not on its shared pad");
    chk_alt_undriven: assert property ((pad_drive.oe & 16'haa99) == 16'h0000)
        else $error("alternate capture pad is driven");
    chk_bvalid_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    chk_rvalid_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    chk_write_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid && !awready)
        else $error("write response missing");
    chk_read_upper: assert property (arvalid && arready |=> rvalid && rdata[31:12] == 20'h00000)
        else $error("read answer late or upper bits set");
    chk_reset_clear: assert property (disable iff (1'b0) !aresetn |=> irq_request == 4'h0 && timer_capture == 8'h00 && !bvalid)
        else $error("outputs not cleared by reset");
    chk_irq_follow: assert property (($stable(port2_in[0]) && port2_in[0] == port6_in[0])[*7]
        |-> irq_request[0] == port2_in[0])
        else $error("request 8 does not follow its pad");
    chk_cap_follow: assert property (($stable(port3_in[2]) && port3_in[2] == port3_in[3])[*7]
        |-> timer_capture[0] == port3_in[2])
        else $error("channel 0 C capture does not follow its pad");
endmodule

bind tips_pin_select tips_pin_select_properties i_tips_pin_select_properties (
    .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
    .arvalid, .arready, .rdata, .rvalid, .rready, .port2_in, .port3_in, .port6_in,
    .pad_drive, .timer_compare, .timer_capture, .irq_request
);
`default_nettype wire

// File: tips_timer_model.sv
// Model of the timer channels that drive compare levels into the block.
// Assumes the timers run on aclk and hold compare drive off during reset.
`timescale 1ns/1ps
`default_nettype none

module tips_timer_model
    import tips_pkg::*;
(
    input  wire logic   aclk,
    input  wire logic   aresetn,
    input  wire logic [7:0] level_req,
    input  wire logic [7:0] oe_req,
    output tips_cmp_type timer_compare
);
    // Compare drive is launched from a flop, as a timer channel would.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_compare <= '0;
        end else begin
            timer_compare <= {level_req, oe_req};
        end
    end
endmodule
`default_nettype wire

// File: tips_pin_select_tb_top.sv
// Self-checking bench for the pin select block over AXI4-Lite.
// Assumes the package constants and the timer model beside the design.
`timescale 1ns/1ps
`default_nettype none

module tips_pin_select_tb_top;
    import tips_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, port6_in = 4'h0, wstrb = 4'h1, irq_request;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp, resp;
    logic [7:0] port2_in = 8'h00, port3_in = 8'h00, timer_capture, lvl_req = 8'h00, oe_req = 8'h00;
    logic [31:0] rd;
    tips_pad_type pad_drive;
    tips_cmp_type timer_compare;
    int error_cnt = 0, cmp_count = 0, cyc = 0;

    always #20 aclk = ~aclk;

    tips_timer_model i_tips_timer_model (.aclk(aclk), .aresetn(aresetn), .level_req(lvl_req),
        .oe_req(oe_req), .timer_compare(timer_compare));
    tips_pin_select i_tips_pin_select (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .port2_in(port2_in), .port3_in(port3_in), .port6_in(port6_in), .pad_drive(pad_drive),
        .timer_compare(timer_compare), .timer_capture(timer_capture), .irq_request(irq_request));

    // ----------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Write with both channels offered together; each dropped when taken.
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        bit aw_done = 0, w_done = 0;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        // Only bvalid or the bench timeout ends this wait.
        while (1'b1) begin
            @(posedge aclk);
            if (bvalid) begin
                resp = bresp;
                break;
            end
            if (!aw_done && awready) begin aw_done = 1; awvalid <= 1'b0; end
            if (!w_done && wready) begin w_done = 1; wvalid <= 1'b0; end
        end
        bready <= 1'b0;
    endtask

    // Read holding rready until the data are seen.
    task automatic axi_rd(input logic [3:0] a);
        bit ar_done = 0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        // Only rvalid or the bench timeout ends this wait.
        while (1'b1) begin
            @(posedge aclk);
            if (rvalid) begin
                rd = rdata; resp = rresp;
                break;
            end
            if (!ar_done && arready) begin ar_done = 1; arvalid <= 1'b0; end
        end
        rready <= 1'b0;
    endtask

    task automatic settle();
        repeat (8) @(posedge aclk);
    endtask

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_reset_values();
        axi_rd(TIPS_OFS_TMR_SEL); chk("tmr_sel reset", rd, 32'h0);
        axi_rd(TIPS_OFS_IRQ_SEL); chk("irq_sel reset", rd, 32'h0);
        $display("test reset values done");
    endtask

    task automatic t_register_map();
        axi_wr(TIPS_OFS_TMR_SEL, 32'h0000_00a5); axi_rd(TIPS_OFS_TMR_SEL); chk("tmr_sel rw", rd, 32'ha5);
        // A write with lane 0 off is answered but must leave the register alone.
        wstrb <= 4'h0;
        axi_wr(TIPS_OFS_TMR_SEL, 32'h0000_005a);
        chk("masked write resp", resp, TIPS_RESP_OKAY);
        wstrb <= 4'h1;
        axi_rd(TIPS_OFS_TMR_SEL);
        chk("masked write kept", rd, 32'ha5);
        axi_wr(TIPS_OFS_IRQ_SEL, 32'h0000_000f); axi_rd(TIPS_OFS_IRQ_SEL); chk("irq_sel upper", rd, 32'h0f);
        axi_wr(4'hc, 32'h0000_0011); chk("unmapped write", resp, TIPS_RESP_SLVERR);
        axi_rd(4'hc); chk("unmapped read", {rd[29:0], resp}, {30'h0, TIPS_RESP_SLVERR});
        axi_wr(TIPS_OFS_PIN_STATE, 32'h1); chk("state write", resp, TIPS_RESP_SLVERR);
        $display("test register map done");
    endtask

    // Shared pins high and alternates low, so each capture shows its source.
    task automatic t_timer_route();
        logic [7:0] s;
        {port3_in, port2_in} <= 16'h5566; lvl_req <= 8'hff; oe_req <= 8'hff;
        for (int i = 0; i < 10; i++) begin
            s = (i == 8) ? 8'h00 : (i == 9) ? 8'hff : 8'h01 << i;
            axi_wr(TIPS_OFS_TMR_SEL, {24'h0, s});
            settle();
            chk("capture route", timer_capture, 8'(~s));
            chk("compare pads", {pad_drive.level & 16'h5566, pad_drive.oe}, {16'h5566, 16'h5566});
        end
        axi_rd(TIPS_OFS_PIN_STATE); chk("pin state", rd[7:0], 8'h00);
        $display("test timer route done");
    endtask

    task automatic t_irq_route();
        logic [3:0] s;
        port2_in <= 8'h05; port6_in <= 4'ha;
        for (int i = 0; i < 6; i++) begin
            s = (i == 4) ? 4'h0 : (i == 5) ? 4'hf : 4'h1 << i;
            // Walking compare drive lets the pad map checks tell functions apart.
            lvl_req <= 8'h01 << i;
            oe_req <= 8'h80 >> i;
            axi_wr(TIPS_OFS_IRQ_SEL, {28'h0, s});
            settle();
            chk("irq route", irq_request, (4'h5 & ~s) | (4'ha & s));
        end
        axi_rd(TIPS_OFS_PIN_STATE); chk("irq state", rd[11:8], 4'ha);
        $display("test irq route done");
    endtask

    task automatic t_mid_reset();
        axi_wr(TIPS_OFS_TMR_SEL, 32'h3c);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(TIPS_OFS_TMR_SEL); chk("tmr_sel rereset", rd, 32'h0);
        axi_rd(TIPS_OFS_IRQ_SEL); chk("irq_sel rereset", rd, 32'h0);
        $display("test mid reset done");
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Cuts a hung run short.
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_values();
        t_register_map();
        t_timer_route();
        t_irq_route();
        t_mid_reset();
        end_of_test();
    end
endmodule
`default_nettype wire
